/* File: common/qm_pkg.sv */
package qm_pkg;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int LOAD_HOLD_NS = 300;
  localparam int LOAD_HOLD_CYC = (LOAD_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] LOAD_HOLD_LAST = 5'(LOAD_HOLD_CYC - 1);
  localparam logic [3:0] SCAN_DIV_LAST = 4'h3;
  localparam int BAUD_UNIT_CYC = 16;

  // Register indices; byte address is four times the index
  localparam logic [2:0] REG_CSR = 3'h0;
  localparam logic [2:0] REG_RECEIVE_BUFFER_REG_LPR = 3'h2;
  localparam logic [2:0] REG_TCR = 3'h4;
  localparam logic [2:0] REG_MSR_TDR = 3'h6;

  // control_status_reg fields
  localparam int CSR_LOOPBACK_BIT_A = 3;
  localparam int CSR_CLR = 4;
  localparam int CSR_MSE = 5;
  localparam int CSR_RIE = 6;
  localparam int CSR_SAE = 12;
  localparam int CSR_TIE = 14;

  // line_param_reg fields
  localparam int LPR_LEN = 3;
  localparam int LPR_STOP = 5;
  localparam int LPR_PAREN = 6;
  localparam int LPR_ODD = 7;
  localparam int LPR_SPEED = 8;
  localparam int LPR_RXEN = 12;
  localparam logic [3:0] CHAR_LEN_BASE = 4'h5;

  // transmit_control_reg and transmit_data_reg high-byte fields
  localparam int TCR_DTR = 8;
  localparam int TDR_BRK = 8;

  // Silo
  localparam int SILO_DEPTH = 64;
  localparam logic [4:0] SILO_ALARM_LVL = 5'h10;

  // Reset values
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [12:0] LPR_RST = 13'h0000;

endpackage : qm_pkg

/* File: common/line_if.sv */
`timescale 1ns/1ns
interface line_if;
  logic [1:0] len_sel;
  logic two_stop;
  logic par_en;
  logic odd_parity_bit;
  logic rx_en;
  logic [3:0] speed;
  logic tx_load;
  logic [7:0] tx_data;
  logic tx_break;
  logic tx_empty;
  logic rx_avail;
  logic [10:0] rx_word;
  logic rx_clr;
  logic serial_in;
  logic serial_out;
  modport ctrl (output len_sel, two_stop, par_en, odd_parity_bit, rx_en, speed, tx_load,
    tx_data, tx_break, rx_clr, serial_in, input tx_empty, rx_avail, rx_word, serial_out);
  modport port (input len_sel, two_stop, par_en, odd_parity_bit, rx_en, speed, tx_load,
    tx_data, tx_break, rx_clr, serial_in, output tx_empty, rx_avail, rx_word, serial_out);
endinterface : line_if

/* File: src/serial_line.sv */
`timescale 1ns/1ns
module serial_line (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  line_if.port lp
);
  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_MARK} rx_state_e;

  logic [15:0] per;
  logic [3:0] len;
  logic [7:0] mask;
  logic [3:0] rx_bits;
  assign per = 16'((32'(lp.speed) + 1) * qm_pkg::BAUD_UNIT_CYC);
  assign len = qm_pkg::CHAR_LEN_BASE + {2'h0, lp.len_sel}; // R3
  assign mask = 8'(8'hFF >> (4'h8 - len));
  assign rx_bits = len + {3'h0, lp.par_en};

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] hold_q;
  logic full_q;
  logic busy_q;
  logic [11:0] tsh_q;
  logic [3:0] tleft_q;
  logic [15:0] ttmr_q;
  logic out_q;
  logic [11:0] frame;
  logic tpar;
  assign tpar = ^(hold_q & mask) ^ lp.odd_parity_bit; // R18
  assign lp.tx_empty = ~full_q;
  assign lp.serial_out = out_q;

  always_comb begin
    frame = 12'hFFF;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 32'(len)) frame[i + 1] = hold_q[i];
    end
    if (lp.par_en) frame[len + 4'h1] = tpar; // R18
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hold_q <= 8'h00;
      full_q <= 1'b0;
      busy_q <= 1'b0;
      tsh_q <= 12'hFFF;
      tleft_q <= 4'h0;
      ttmr_q <= 16'h0000;
      out_q <= 1'b1;
    end else begin
      if (lp.tx_load) begin
        hold_q <= lp.tx_data;
        full_q <= 1'b1;
      end
      if (!busy_q && full_q) begin
        tsh_q <= frame;
        tleft_q <= 4'h2 + rx_bits + {3'h0, lp.two_stop};
        ttmr_q <= per - 16'h1;
        busy_q <= 1'b1;
        full_q <= 1'b0;
      end else if (busy_q) begin
        if (ttmr_q == 16'h0000) begin
          ttmr_q <= per - 16'h1;
          tsh_q <= {1'b1, tsh_q[11:1]};
          tleft_q <= tleft_q - 4'h1;
          if (tleft_q == 4'h1) busy_q <= 1'b0;
        end else begin
          ttmr_q <= ttmr_q - 16'h1;
        end
      end
      // Break overrides any character in flight
      out_q <= lp.tx_break ? 1'b0 : (busy_q ? tsh_q[0] : 1'b1); // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rx_state_e st_q;
  logic [15:0] rtmr_q;
  logic [3:0] rcnt_q;
  logic [8:0] rsh_q;
  logic da_q;
  logic [10:0] word_q;
  logic [8:0] aligned;
  logic [7:0] rdata;
  logic perr;
  assign aligned = rsh_q >> (4'h9 - rx_bits);
  assign rdata = aligned[7:0] & mask;
  assign perr = lp.par_en & (^rdata ^ lp.odd_parity_bit ^ aligned[len]); // R18
  assign lp.rx_avail = da_q;
  assign lp.rx_word = word_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= RX_IDLE;
      rtmr_q <= 16'h0000;
      rcnt_q <= 4'h0;
      rsh_q <= 9'h000;
      da_q <= 1'b0;
      word_q <= 11'h000;
    end else begin
      if (lp.rx_clr) da_q <= 1'b0;
      case (st_q)
        RX_IDLE: begin
          if (lp.rx_en && !lp.serial_in) begin // R26
            st_q <= RX_START;
            rtmr_q <= per >> 1;
          end
        end
        RX_START: begin
          if (rtmr_q != 16'h0000) begin
            rtmr_q <= rtmr_q - 16'h1;
          end else if (lp.serial_in) begin
            st_q <= RX_IDLE;
          end else begin
            st_q <= RX_BITS;
            rtmr_q <= per - 16'h1;
            rcnt_q <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rtmr_q != 16'h0000) begin
            rtmr_q <= rtmr_q - 16'h1;
          end else begin
            rsh_q <= {lp.serial_in, rsh_q[8:1]};
            rcnt_q <= rcnt_q + 4'h1;
            rtmr_q <= per - 16'h1;
            if (rcnt_q == rx_bits - 4'h1) st_q <= RX_STOP; // R3
          end
        end
        RX_STOP: begin
          if (rtmr_q != 16'h0000) begin
            rtmr_q <= rtmr_q - 16'h1;
          end else begin
            da_q <= 1'b1;
            // Stop sampled at space gives a framing error, so a break does too
            word_q <= {da_q & ~lp.rx_clr, ~lp.serial_in, perr, rdata}; // R20 R2
            st_q <= lp.serial_in ? RX_IDLE : RX_MARK;
          end
        end
        RX_MARK: begin
          if (lp.serial_in) st_q <= RX_IDLE;
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end
endmodule : serial_line

/* File: src/quad_async_serial_multiplexer.sv */
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
// Operation
// (R1) Break bit holds its line at space
// (R2) Continuous space is received as framing error
// (R3) Length select sets receive and transmit length
// (R4) Clear bit drives master clear
// (R5) Init from clear bit or bus initialize
// (R6) Modem status 11:8 show carrier 3:0
// (R7) Buffer read latches done as valid bit
// (R8) Done is silo output ready, shown in status
// (R9) Control bits 11:8 drive terminal ready 0:3
// (R10) Control bits 3:0 enable line transmission
// (R11) Parameter write targets line in bits 1:0
// (R12) Parameter or data writes delay reply 300 ns
// (R13) Maintenance loops each output to its input
// (R14) Scan enable gates scanning and scan clock
// (R15) Scan clock divided from system clock
// (R16) Buffer bits 14:12 overrun, framing, parity
// (R17) Received character in buffer bits 7:0
// (R18) Bit 6 parity enable, bit 7 odd
// (R19) Modem status 3:0 show ring 0:3
// (R20) Stop bit at space flags framing error
// (R21) Status bit 6 is receive interrupt enable
// (R22) Buffer read advances the silo
// (R23) Alarm after 16 characters, cleared by read
// (R24) Status 12 alarm enable, 13 alarm
// (R25) Status 9:8 line, 15 ready, 14 enable
// (R26) Speed 11:8, stop 5, receive enable 12
module quad_async_serial_multiplexer (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [3:0] i_serial_in,
  output logic [3:0] o_serial_out,
  output logic [3:0] o_terminal_ready,
  input wire logic [3:0] i_carrier,
  input wire logic [3:0] i_ring
);

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  logic clr_q;
  logic init;
  logic loopback_bit_a_q;
  logic mse_q;
  logic rie_q;
  logic sae_q;
  logic tie_q;
  logic [3:0] line_en_q;
  logic [3:0] dtr_q;
  logic [3:0] break_q;
  logic [12:0] lpr_q [4];

  // Master clear is a one-cycle pulse: it clears itself along with the rest
  assign init = i_rst | clr_q; // R5 R4

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic wait_q;
  logic [4:0] hold_cnt_q;
  logic [31:0] rdata_q;
  logic req;
  logic load_wr;
  logic go;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_mux;

  assign req = i_avs_read | i_avs_write;
  assign load_wr = i_avs_write &
    ((i_avs_address == qm_pkg::REG_RECEIVE_BUFFER_REG_LPR) | (i_avs_address == qm_pkg::REG_MSR_TDR));
  assign go = req & wait_q & (!load_wr || (hold_cnt_q == qm_pkg::LOAD_HOLD_LAST)); // R12
  assign wr_go = go & i_avs_write;
  assign rd_go = go & i_avs_read;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wait_q <= 1'b1;
      hold_cnt_q <= 5'h00;
    end else begin
      wait_q <= ~go;
      // Loads hold off the answer for a fixed LOAD_HOLD_CYC cycles, whether or not the line logic takes them
      hold_cnt_q <= (req && wait_q && !go) ? hold_cnt_q + 5'h01 : 5'h00; // R12
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_q <= qm_pkg::RDATA_RST;
    end else if (rd_go) begin
      rdata_q <= rd_mux; // R7
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;

  logic csr_wr;
  logic lpr_wr;
  logic tcr_wr;
  logic tdr_wr;
  logic receive_buffer_reg_rd;
  assign csr_wr = wr_go & (i_avs_address == qm_pkg::REG_CSR);
  assign lpr_wr = wr_go & (i_avs_address == qm_pkg::REG_RECEIVE_BUFFER_REG_LPR);
  assign tcr_wr = wr_go & (i_avs_address == qm_pkg::REG_TCR);
  assign tdr_wr = wr_go & (i_avs_address == qm_pkg::REG_MSR_TDR);
  assign receive_buffer_reg_rd = rd_go & (i_avs_address == qm_pkg::REG_RECEIVE_BUFFER_REG_LPR);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      clr_q <= 1'b0;
      loopback_bit_a_q <= 1'b0;
      mse_q <= 1'b0;
      rie_q <= 1'b0;
    end else if (csr_wr && i_avs_byteenable[0]) begin
      clr_q <= i_avs_writedata[qm_pkg::CSR_CLR]; // R4
      loopback_bit_a_q <= i_avs_writedata[qm_pkg::CSR_LOOPBACK_BIT_A]; // R13
      mse_q <= i_avs_writedata[qm_pkg::CSR_MSE]; // R14
      rie_q <= i_avs_writedata[qm_pkg::CSR_RIE]; // R21
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      sae_q <= 1'b0;
      tie_q <= 1'b0;
    end else if (csr_wr && i_avs_byteenable[1]) begin
      sae_q <= i_avs_writedata[qm_pkg::CSR_SAE]; // R24
      tie_q <= i_avs_writedata[qm_pkg::CSR_TIE]; // R25
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      line_en_q <= 4'h0;
      dtr_q <= 4'h0;
    end else if (tcr_wr) begin
      if (i_avs_byteenable[0]) line_en_q <= i_avs_writedata[3:0]; // R10
      if (i_avs_byteenable[1]) dtr_q <= i_avs_writedata[qm_pkg::TCR_DTR +: 4]; // R9
    end
  end

  assign o_terminal_ready = dtr_q; // R9

  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      break_q <= 4'h0;
    end else if (tdr_wr && i_avs_byteenable[1]) begin
      break_q <= i_avs_writedata[qm_pkg::TDR_BRK +: 4]; // R1
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      for (int i = 0; i < 4; i++) begin
        lpr_q[i] <= qm_pkg::LPR_RST;
      end
    end else if (lpr_wr) begin
      // Only the addressed line takes the new speed and format
      lpr_q[i_avs_writedata[1:0]] <= i_avs_writedata[12:0]; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan clock
  logic [3:0] scan_cnt_q;
  logic scan_tick;

  always_ff @(posedge i_sys_clk) begin
    if (init || !mse_q) begin
      scan_cnt_q <= 4'h0; // R14
    end else if (scan_cnt_q == qm_pkg::SCAN_DIV_LAST) begin
      scan_cnt_q <= 4'h0; // R15
    end else begin
      scan_cnt_q <= scan_cnt_q + 4'h1; // R15
    end
  end

  assign scan_tick = mse_q & (scan_cnt_q == qm_pkg::SCAN_DIV_LAST); // R14 R15

  ////////////////////////////////////////////////////////////////////////////
  // Lines
  line_if lif [4] ();
  logic [3:0] tx_empty;
  logic [3:0] rx_avail;
  logic [10:0] rx_word [4];
  logic [3:0] line_out;
  logic [1:0] tline_q;
  logic tx_ready_status_q;
  logic [1:0] rline_q;
  logic push;
  logic silo_full;

  for (genvar g = 0; g < 4; g++) begin : g_line
    assign lif[g].len_sel = lpr_q[g][qm_pkg::LPR_LEN +: 2]; // R3
    assign lif[g].two_stop = lpr_q[g][qm_pkg::LPR_STOP]; // R26
    assign lif[g].par_en = lpr_q[g][qm_pkg::LPR_PAREN]; // R18
    assign lif[g].odd_parity_bit = lpr_q[g][qm_pkg::LPR_ODD]; // R18
    assign lif[g].speed = lpr_q[g][qm_pkg::LPR_SPEED +: 4]; // R26
    assign lif[g].rx_en = lpr_q[g][qm_pkg::LPR_RXEN]; // R26
    assign lif[g].tx_load = tdr_wr & i_avs_byteenable[0] & tx_ready_status_q & (tline_q == 2'(g));
    assign lif[g].tx_data = i_avs_writedata[7:0];
    assign lif[g].tx_break = break_q[g]; // R1
    assign lif[g].rx_clr = push & (rline_q == 2'(g));
    assign lif[g].serial_in = loopback_bit_a_q ? line_out[g] : i_serial_in[g]; // R13
    assign tx_empty[g] = lif[g].tx_empty;
    assign rx_avail[g] = lif[g].rx_avail;
    assign rx_word[g] = lif[g].rx_word;
    assign line_out[g] = lif[g].serial_out;

    serial_line u_line (
      .i_sys_clk(i_sys_clk),
      .i_rst(init),
      .lp(lif[g])
    );
  end

  assign o_serial_out = line_out;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit scanner
  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      tline_q <= 2'h0;
      tx_ready_status_q <= 1'b0;
    end else if (!mse_q) begin
      tx_ready_status_q <= 1'b0; // R14
    end else if (tx_ready_status_q) begin
      // A load or a disabled line releases the scanner to move on
      if ((tdr_wr && i_avs_byteenable[0]) || !line_en_q[tline_q]) begin
        tx_ready_status_q <= 1'b0; // R10
      end
    end else if (scan_tick) begin
      if (line_en_q[tline_q] && tx_empty[tline_q]) begin
        tx_ready_status_q <= 1'b1; // R10 R25
      end else begin
        tline_q <= tline_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive scanner and silo
  logic [12:0] silo_mem [qm_pkg::SILO_DEPTH];
  logic [5:0] wr_ptr_q;
  logic [5:0] rd_ptr_q;
  logic [6:0] count_q;
  logic rx_done_status;
  logic pop;
  logic [12:0] silo_out;

  assign silo_full = count_q == 7'(qm_pkg::SILO_DEPTH);
  assign push = scan_tick & rx_avail[rline_q] & ~silo_full; // R14
  // One storage array, so its output-ready is the whole silo's
  assign rx_done_status = count_q != 7'h00; // R8
  assign pop = receive_buffer_reg_rd & rx_done_status; // R22
  assign silo_out = silo_mem[rd_ptr_q];

  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      rline_q <= 2'h0;
    end else if (scan_tick) begin
      rline_q <= rline_q + 2'h1; // R15
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      silo_mem[wr_ptr_q] <= {rx_word[rline_q][10:8], rline_q, rx_word[rline_q][7:0]};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (init) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      count_q <= 7'h00;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 6'h01;
      if (pop) rd_ptr_q <= rd_ptr_q + 6'h01; // R22
      count_q <= count_q + {6'h00, push} - {6'h00, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Silo alarm
  logic [4:0] sa_cnt_q;
  logic sa_q;
  logic sa_set;

  assign sa_set = push & (sa_cnt_q == qm_pkg::SILO_ALARM_LVL - 5'h01); // R23

  always_ff @(posedge i_sys_clk) begin
    if (init || !sae_q) begin
      sa_cnt_q <= 5'h00; // R23
      sa_q <= 1'b0;
    end else if (receive_buffer_reg_rd) begin
      // A character arriving with the read still counts toward the next alarm
      sa_cnt_q <= {4'h0, push}; // R23
      sa_q <= sa_set;
    end else begin
      if (push && sa_cnt_q != qm_pkg::SILO_ALARM_LVL) sa_cnt_q <= sa_cnt_q + 5'h01;
      sa_q <= sa_q | sa_set; // R23 R24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      qm_pkg::REG_CSR: begin
        rd_mux[15:0] = {tx_ready_status_q, tie_q, sa_q, sae_q, 2'h0, tline_q, rx_done_status, rie_q,
          mse_q, clr_q, loopback_bit_a_q, 3'h0}; // R8 R21 R24 R25
      end
      qm_pkg::REG_RECEIVE_BUFFER_REG_LPR: begin
        rd_mux[15:0] = {rx_done_status, silo_out[12:10], 2'h0, silo_out[9:0]}; // R7 R16 R17
      end
      qm_pkg::REG_TCR: begin
        rd_mux[15:0] = {4'h0, dtr_q, 4'h0, line_en_q};
      end
      qm_pkg::REG_MSR_TDR: begin
        rd_mux[15:0] = {4'h0, i_carrier, 4'h0, i_ring}; // R6 R19
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

endmodule : quad_async_serial_multiplexer

/* File: dv/mux_sva.sv */
`timescale 1ns/1ns
module mux_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [3:0] i_serial_in,
  input wire logic [3:0] o_serial_out,
  input wire logic [3:0] o_terminal_ready,
  input wire logic [3:0] i_carrier,
  input wire logic [3:0] i_ring
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic load_addr;
  logic [3:0] hi_nib;
  assign load_addr = i_avs_address == qm_pkg::REG_RECEIVE_BUFFER_REG_LPR || i_avs_address == qm_pkg::REG_MSR_TDR;
  assign hi_nib = i_avs_writedata[11:8];
  //////////////////////////////////////////////////////////////////////////////
  sequence s_load_wr;
    $rose(i_avs_write) && load_addr;
  endsequence
  sequence s_quick_req;
    $rose(i_avs_read) || ($rose(i_avs_write) && !load_addr);
  endsequence
  sequence s_held;
    o_avs_waitrequest throughout (1'b1 ##28 1'b1);
  endsequence
  property p_load_hold;
    s_load_wr |=> s_held ##1 !o_avs_waitrequest;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("load reply not held");
  property p_quick_reply;
    s_quick_req |=> !o_avs_waitrequest;
  endproperty
  a_quick_reply: assert property (p_quick_reply) else $error("reply late");
  property p_reply_pulse;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_reply_pulse: assert property (p_reply_pulse) else $error("reply too long");
  property p_modem;
    $rose(i_avs_read) && i_avs_address == qm_pkg::REG_MSR_TDR
      |=> o_avs_readdata == {20'h00000, $past(i_carrier), 4'h0, $past(i_ring)};
  endproperty
  a_modem: assert property (p_modem) else $error("modem status wrong");
  property p_dtr;
    $rose(i_avs_write) && i_avs_address == qm_pkg::REG_TCR && i_avs_byteenable[1]
      |=> ##1 o_terminal_ready == $past(hi_nib, 2);
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready wrong");
  property p_break;
    $rose(i_avs_write) && i_avs_address == qm_pkg::REG_MSR_TDR && i_avs_byteenable[1]
      |-> ##34 (o_serial_out & $past(hi_nib, 34)) == 4'h0;
  endproperty
  a_break: assert property (p_break) else $error("break line not spacing");
  property p_clear;
    $rose(i_avs_write) && i_avs_address == qm_pkg::REG_CSR && i_avs_byteenable[0]
      && i_avs_writedata[qm_pkg::CSR_CLR] |-> ##[2:5] o_terminal_ready == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear bit had no effect");
  property p_init;
    $fell(i_rst) |-> o_avs_waitrequest && o_terminal_ready == 4'h0 && o_serial_out == 4'hF;
  endproperty
  a_init: assert property (p_init) else $error("state after init wrong");
endmodule : mux_sva

/* File: dv/serial_terminal.sv */
`timescale 1ns/1ns
module serial_terminal (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_serial_out,
  output logic [3:0] o_serial_in,
  output logic [8:0] o_got,
  output logic o_got_stb
);
  // Speed code 0 gives sixteen clocks a bit
  localparam int BIT_CYC = 16;
  initial begin
    o_serial_in = 4'hF;
    o_got = 9'h000;
    o_got_stb = 1'b0;
  end
  // Eight data bits, odd parity, one stop; lines idle at mark
  task automatic send(input int ln, input logic [7:0] d);
    logic [10:0] f;
    f = {1'b1, ~^d, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_serial_in[ln] <= f[i];
      repeat (BIT_CYC) @(posedge i_sys_clk);
    end
  endtask : send
  task automatic space(input int ln, input int n);
    o_serial_in[ln] <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
    o_serial_in[ln] <= 1'b1;
  endtask : space
  // Decodes line 1 only; a frame seen during break is still reported
  initial begin : decode
    logic [8:0] sh;
    forever begin
      wait (i_serial_out[1] === 1'b1);
      wait (i_serial_out[1] === 1'b0);
      repeat (BIT_CYC / 2) @(posedge i_sys_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge i_sys_clk);
        sh[i] = i_serial_out[1];
      end
      o_got <= sh;
      o_got_stb <= 1'b1;
      @(posedge i_sys_clk);
      o_got_stb <= 1'b0;
    end
  end
endmodule : serial_terminal

/* File: dv/test_quad_async_serial_multiplexer.sv */
`timescale 1ns/1ns
module test_quad_async_serial_multiplexer;
  localparam logic [2:0] A_CSR = qm_pkg::REG_CSR;
  localparam logic [2:0] A_RECEIVE_BUFFER_REG = qm_pkg::REG_RECEIVE_BUFFER_REG_LPR;
  localparam logic [2:0] A_TCR = qm_pkg::REG_TCR;
  localparam logic [2:0] A_MSR = qm_pkg::REG_MSR_TDR;
  logic i_sys_clk = 1'b0;
  logic i_rst, i_avs_read, i_avs_write, o_avs_waitrequest, got_stb;
  logic [2:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0] i_avs_byteenable, i_carrier, i_ring, i_serial_in, o_serial_out, o_terminal_ready;
  logic [8:0] got;
  logic [15:0] rd_exp_q[$], rd_mask_q[$], tx_q[$];
  logic [15:0] rd;
  logic [7:0] ch[16];
  int bad_count = 0;
  int checks_done = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  quad_async_serial_multiplexer quad_async_serial_multiplexer_inst (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_serial_in(i_serial_in),
    .o_serial_out(o_serial_out), .o_terminal_ready(o_terminal_ready), .i_carrier(i_carrier),
    .i_ring(i_ring));
  serial_terminal serial_terminal_inst (.i_sys_clk(i_sys_clk), .i_serial_out(o_serial_out),
    .o_serial_in(i_serial_in), .o_got(got), .o_got_stb(got_stb));
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  // Holds the request until the reply; the monitor checks read data on the reply edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d,
    input logic [3:0] be, input logic [15:0] exp, input logic [15:0] m);
    int n;
    n = 0;
    if (!wr) begin
      rd_exp_q.push_back(exp);
      rd_mask_q.push_back(m);
    end
    i_avs_address <= a;
    i_avs_writedata <= {16'h0000, d};
    i_avs_byteenable <= be;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata[15:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_sys_clk);
    cmp("reply cycles", (wr && (a == A_RECEIVE_BUFFER_REG || a == A_MSR)) ?
      16'(qm_pkg::LOAD_HOLD_CYC + 1) : 16'h0002, 16'(n));
  endtask : bus
  task automatic rdr(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] m);
    bus(1'b0, a, 16'h0000, 4'h0, exp, m);
  endtask : rdr
  task automatic wrr(input logic [2:0] a, input logic [15:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be, 16'h0000, 16'h0000);
  endtask : wrr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge i_sys_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0 && rd_exp_q.size() > 0) begin
      cmp("read data", rd_exp_q.pop_front(), o_avs_readdata[15:0] & rd_mask_q.pop_front());
    end
    // Frames with nothing queued come from break and are not judged
    if (got_stb === 1'b1 && tx_q.size() > 0)
      cmp("serial char", tx_q.pop_front(), {7'h00, got});
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    i_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 3'h0;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'h0;
    i_carrier = 4'h0;
    i_ring = 4'h0;
    void'($urandom(32'hB035));
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    cmp("serial idle", 16'h000F, {12'h000, o_serial_out});
    rdr(3'h3, 16'h0000, 16'hFFFF);
    wrr(A_TCR, 16'h0A02, 4'h3);
    rdr(A_TCR, 16'h0A02, 16'hFFFF);
    cmp("terminal ready", 16'h000A, {12'h000, o_terminal_ready});
    for (int i = 0; i < 4; i++) begin
      i_carrier <= 4'($urandom);
      i_ring <= 4'($urandom);
      @(posedge i_sys_clk);
      rdr(A_MSR, {4'h0, i_carrier, 4'h0, i_ring}, 16'hFFFF);
    end
    wrr(A_RECEIVE_BUFFER_REG, 16'h10D9, 4'h3);
    wrr(A_RECEIVE_BUFFER_REG, 16'h0000, 4'h3);
    wrr(A_CSR, 16'h1060, 4'h3);
    rdr(A_CSR, 16'h1060, 16'h50F8);
    ch[0] = 8'($urandom);
    serial_terminal_inst.send(1, ch[0]);
    repeat (40) @(posedge i_sys_clk);
    rdr(A_CSR, 16'h0080, 16'h0080);
    rdr(A_RECEIVE_BUFFER_REG, {8'h81, ch[0]}, 16'hF3FF);
    rdr(A_RECEIVE_BUFFER_REG, 16'h0000, 16'h8000);
    serial_terminal_inst.space(1, 300);
    repeat (200) @(posedge i_sys_clk);
    // An all-space frame also fails odd parity
    rdr(A_RECEIVE_BUFFER_REG, 16'hB100, 16'hB300);
    // The alarm must stay clear at fifteen characters and set at sixteen
    for (int i = 0; i < 16; i++) begin
      if (i == 15) begin
        repeat (20) @(posedge i_sys_clk);
        rdr(A_CSR, 16'h0000, 16'h2000);
      end
      ch[i] = 8'($urandom);
      serial_terminal_inst.send(1, ch[i]);
    end
    repeat (20) @(posedge i_sys_clk);
    rdr(A_CSR, 16'h2000, 16'h2000);
    for (int i = 0; i < 16; i++) rdr(A_RECEIVE_BUFFER_REG, {8'h81, ch[i]}, 16'hF3FF);
    rdr(A_CSR, 16'h0000, 16'h2080);
    wrr(A_CSR, 16'h1068, 4'h3);
    rd = 16'h0000;
    for (int k = 0; k < 50 && !rd[15]; k++) rdr(A_CSR, 16'h0000, 16'h0000);
    cmp("tx line", 16'h8100, rd & 16'h8300);
    ch[0] = 8'($urandom);
    tx_q.push_back({7'h00, ~^ch[0], ch[0]});
    wrr(A_MSR, {8'h00, ch[0]}, 4'h1);
    repeat (260) @(posedge i_sys_clk);
    cmp("tx pending", 16'h0000, 16'(tx_q.size()));
    rdr(A_RECEIVE_BUFFER_REG, {8'h81, ch[0]}, 16'hF3FF);
    wrr(A_MSR, 16'h0200, 4'h2);
    repeat (40) @(posedge i_sys_clk);
    cmp("break level", 16'h0000, {15'h0000, o_serial_out[1]});
    wrr(A_MSR, 16'h0000, 4'h2);
    wrr(A_CSR, 16'h0010, 4'h1);
    repeat (4) @(posedge i_sys_clk);
    cmp("terminal ready", 16'h0000, {12'h000, o_terminal_ready});
    rdr(A_TCR, 16'h0000, 16'hFFFF);
    rdr(A_CSR, 16'h0000, 16'h10F8);
    report_and_stop();
  end
endmodule : test_quad_async_serial_multiplexer
bind quad_async_serial_multiplexer mux_sva mux_sva_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_serial_in(i_serial_in), .o_serial_out(o_serial_out), .o_terminal_ready(o_terminal_ready),
  .i_carrier(i_carrier), .i_ring(i_ring));
